/* inc/phs_pkg.sv */
// Purpose: shared constants for the bus-side signalling of a card-socket controller
// Assumes: one clock domain, sys_clk at 10 MHz
// Notes: used by both ends and the interface
//
// Behaviour
// [RL1] device flags write data parity errors low
// [RL2] device pulses system error on address parity
// [RL3] parity valid cycle after address/write phase
// [RL4] device drives read parity after target ready
// [RL5] parity makes total ones count even
// [RL6] bus signals sampled on rising clock edge
// [RL7] logic works at any clock to limit
// [RL8] reset clears all state, releases pins; clock-run and interrupt pin drives ignore reset
// [RL9] first pin: request A or line nine
// [RL10] second pin: request B, ten, or ring
// [RL11] third pin: request C, serial out, strobe
// [RL12] fourth pin: request D, serial in, data
// [RL13] clock-run read as status, pulled low
// [RL14] request toward arbiter, grant answers it
// [RL15] device select driven and observed
// [RL16] serial interrupt frames follow published protocol
// [RL17] shifter vector order and strobe fixed here
package phs_pkg;
    // ----------------------------------------
    // interrupt signalling modes
    // ----------------------------------------
    typedef enum logic [1:0] {
        PHS_MODE_PCI,
        PHS_MODE_SERIAL,
        PHS_MODE_EXT
    } phs_mode_t;
    // ----------------------------------------
    // widths and timing
    // ----------------------------------------
    localparam int PHS_AD_W = 32;
    localparam int PHS_CBE_W = 4;
    localparam int PHS_VEC_W = 16;
    localparam logic [4:0] PHS_VEC_LAST = 5'h0F;
    localparam int PHS_SERR_NS = 100;
    localparam int PHS_CLK_NS = 100;
    localparam int PHS_SERR_CYC = (PHS_SERR_NS + PHS_CLK_NS - 1) / PHS_CLK_NS;
    localparam int PHS_SLOTS = 4;
    localparam logic [1:0] PHS_SLOT_LAST = 2'h3;
    localparam logic [15:0] PHS_RST_VEC = 16'h0000;
    localparam logic [2:0] PHS_CMD_RD = 3'h3;
    // parity over address/data and command/byte enables
    function automatic logic phs_parity(input logic [31:0] ad, input logic [3:0] cbe);
        phs_parity = ^{ad, cbe}; // RL5
    endfunction
endpackage

/* inc/phs_if.sv */
`timescale 1ns/100ps
// Purpose: bus wires joining the device end and the host end
// Assumes: open-drain lines pulled high when nobody drives
// Notes: resolves each two-way line from its enables
interface phs_if;
    import phs_pkg::*;
    // address/data and command
    logic [31:0] ad_dev, ad_host, ad;
    logic ad_dev_oe, ad_host_oe;
    logic [3:0] cbe_n;
    logic frame_n, irdy_n;
    logic trdy_dev_n, trdy_dev_oe, trdy_n;
    logic devsel_dev_n, devsel_dev_oe, devsel_n;
    // parity
    logic par_dev, par_dev_oe, par_host, par_host_oe, par;
    logic perr_dev_oe, perr_n;
    logic serr_dev_oe, serr_n;
    // arbitration and clock run
    logic req_n, gnt_n;
    logic clkrun_dev_oe, clkrun_host_oe, clkrun_n;
    // interrupt pins
    logic [3:0] int_dev, int_dev_oe, int_pin;
    logic int_host, int_host_oe;
    assign ad = ad_dev_oe ? ad_dev : (ad_host_oe ? ad_host : '1);
    assign trdy_n = trdy_dev_oe ? trdy_dev_n : 1'b1;
    assign devsel_n = devsel_dev_oe ? devsel_dev_n : 1'b1;
    assign par = par_dev_oe ? par_dev : (par_host_oe ? par_host : 1'b1);
    assign perr_n = !perr_dev_oe;
    assign serr_n = !serr_dev_oe;
    assign clkrun_n = !(clkrun_dev_oe || clkrun_host_oe);
    assign int_pin[2:0] = int_dev[2:0] | ~int_dev_oe[2:0];
    assign int_pin[3] = int_dev_oe[3] ? int_dev[3] : (int_host_oe ? int_host : 1'b1);
    modport dev (
        input ad, cbe_n, frame_n, irdy_n, devsel_n, par, gnt_n, clkrun_n, int_pin,
        output ad_dev, ad_dev_oe, trdy_dev_n, trdy_dev_oe, devsel_dev_n, devsel_dev_oe,
        output par_dev, par_dev_oe, perr_dev_oe, serr_dev_oe, req_n, clkrun_dev_oe,
        output int_dev, int_dev_oe
    );
    modport host (
        input ad, trdy_n, devsel_n, par, perr_n, serr_n, req_n, clkrun_n, int_pin,
        output ad_host, ad_host_oe, cbe_n, frame_n, irdy_n, par_host, par_host_oe,
        output gnt_n, clkrun_host_oe, int_host, int_host_oe
    );
endinterface

/* core/phs_dev.sv */
`timescale 1ns/100ps
// Purpose: device end: target parity, error report, arbitration, interrupt pins
// Assumes: single-data-phase target accesses, one wait-free ready
// Notes: all bus inputs are same-clock logic and pass no synchroniser
module phs_dev
    import phs_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // bus
    phs_if.dev bus,
    // user side
    input wire logic [31:0] base_addr,
    input wire logic [31:0] read_data,
    input wire logic need_bus,
    input wire logic clk_request,
    input wire phs_mode_t int_mode,
    input wire logic ring_enable,
    input wire logic socket_status_ring_input,
    input wire logic [15:0] irq_vector,
    output logic [31:0] write_data,
    output logic write_valid,
    output logic bus_granted,
    output logic clock_running,
    output logic card_irq_seen,
    output logic target_seen,
    output logic parity_error,
    output logic address_error
);
    // ----------------------------------------
    // address phase and target decode
    // ----------------------------------------
    logic frame_q, hit, in_data, is_read, addr_chk, wr_chk, rd_par, trdy_q;
    logic [31:0] ad_q;
    logic [3:0] cbe_q;
    logic [1:0] serr_cnt;
    assign hit = frame_q && !bus.frame_n && bus.ad == base_addr; // RL15
    always_ff @(posedge sys_clk or negedge reset_n) begin // RL6 RL7 RL8
        if (!reset_n) begin
            frame_q <= 1'b1;
            in_data <= 1'b0;
            is_read <= 1'b0;
            trdy_q <= 1'b0;
        end else begin
            frame_q <= bus.frame_n;
            trdy_q <= in_data && !bus.irdy_n;
            if (hit) begin
                in_data <= 1'b1;
                is_read <= bus.cbe_n[2:0] == PHS_CMD_RD;
            end else if (in_data && !bus.irdy_n) begin
                in_data <= 1'b0;
            end
        end
    end
    assign bus.devsel_dev_n = 1'b0;
    assign bus.devsel_dev_oe = in_data; // RL15
    assign target_seen = !bus.devsel_n; // RL15
    assign bus.trdy_dev_n = !in_data;
    assign bus.trdy_dev_oe = in_data;
    assign bus.ad_dev = read_data;
    assign bus.ad_dev_oe = in_data && is_read;
    // ----------------------------------------
    // parity check and generation
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ad_q <= 32'h00000000;
            cbe_q <= 4'h0;
            addr_chk <= 1'b0;
            wr_chk <= 1'b0;
            rd_par <= 1'b0;
        end else begin
            ad_q <= bus.ad;
            cbe_q <= bus.cbe_n;
            addr_chk <= frame_q && !bus.frame_n; // RL3
            wr_chk <= in_data && !is_read && !bus.irdy_n; // RL3
            rd_par <= phs_parity(read_data, bus.cbe_n); // RL4 RL5
        end
    end
    assign bus.par_dev = rd_par;
    assign bus.par_dev_oe = trdy_q && is_read; // RL4
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            parity_error <= 1'b0;
            address_error <= 1'b0;
            serr_cnt <= 2'h0;
            write_data <= 32'h00000000;
            write_valid <= 1'b0;
        end else begin
            parity_error <= wr_chk && phs_parity(ad_q, cbe_q) != bus.par; // RL1
            address_error <= addr_chk && phs_parity(ad_q, cbe_q) != bus.par;
            if (addr_chk && phs_parity(ad_q, cbe_q) != bus.par) begin
                serr_cnt <= 2'(PHS_SERR_CYC); // RL2
            end else if (serr_cnt != 2'h0) begin
                serr_cnt <= serr_cnt - 2'h1;
            end
            write_valid <= wr_chk;
            if (wr_chk) begin
                write_data <= ad_q;
            end
        end
    end
    assign bus.perr_dev_oe = parity_error; // RL1
    assign bus.serr_dev_oe = serr_cnt != 2'h0; // RL2
    // ----------------------------------------
    // arbitration and clock run
    // ----------------------------------------
    logic req_q;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            req_q <= 1'b0;
        end else begin
            req_q <= need_bus; // RL14
        end
    end
    assign bus.req_n = !req_q; // RL14
    assign bus_granted = req_q && !bus.gnt_n; // RL14
    assign clock_running = !bus.clkrun_n; // RL13
    assign bus.clkrun_dev_oe = clk_request; // RL13
    // ----------------------------------------
    // external shifter stream
    // ----------------------------------------
    logic [4:0] bit_idx;
    logic [15:0] vec_q;
    logic shf_data, shf_load;
    always_ff @(posedge sys_clk or negedge reset_n) begin // RL17
        if (!reset_n) begin
            bit_idx <= 5'h00;
            vec_q <= PHS_RST_VEC;
            shf_data <= 1'b0;
            shf_load <= 1'b0;
        end else begin
            shf_load <= bit_idx == PHS_VEC_LAST;
            shf_data <= vec_q[bit_idx[3:0]];
            if (bit_idx == PHS_VEC_LAST) begin
                bit_idx <= 5'h00;
                vec_q <= irq_vector;
            end else begin
                bit_idx <= bit_idx + 5'h01;
            end
        end
    end
    // ----------------------------------------
    // serial interrupt frame
    // ----------------------------------------
    logic [1:0] slot;
    logic ser_out, sin_q;
    always_ff @(posedge sys_clk or negedge reset_n) begin // RL16
        if (!reset_n) begin
            slot <= 2'h0;
            ser_out <= 1'b1;
            sin_q <= 1'b1;
        end else begin
            slot <= slot == PHS_SLOT_LAST ? 2'h0 : slot + 2'h1;
            ser_out <= !(irq_vector[slot] || (slot == 2'h0 && !sin_q));
            sin_q <= bus.int_pin[3];
        end
    end
    assign card_irq_seen = !sin_q;
    // ----------------------------------------
    // interrupt pin mux
    // ----------------------------------------
    always_comb begin
        bus.int_dev = 4'hF;
        bus.int_dev_oe = 4'h0;
        unique case (int_mode)
            PHS_MODE_PCI: begin
                bus.int_dev = 4'h0;
                bus.int_dev_oe = irq_vector[3:0]; // RL9 RL10 RL11 RL12
            end
            PHS_MODE_SERIAL: begin
                bus.int_dev[2] = 1'b0;
                bus.int_dev_oe[2] = !ser_out; // RL11
                bus.int_dev_oe[0] = irq_vector[0];
                bus.int_dev[0] = 1'b0;
            end
            PHS_MODE_EXT: begin
                bus.int_dev[0] = irq_vector[9]; // RL9
                bus.int_dev[1] = irq_vector[10]; // RL10
                bus.int_dev[2] = shf_load; // RL11
                bus.int_dev[3] = shf_data; // RL12
                bus.int_dev_oe = 4'hF;
            end
            default: begin
                bus.int_dev = 4'hF;
            end
        endcase
        if (ring_enable) begin
            bus.int_dev[1] = socket_status_ring_input; // RL10
            bus.int_dev_oe[1] = 1'b1;
        end
    end
endmodule

/* core/phs_host.sv */
`timescale 1ns/100ps
// Purpose: host end: initiator, parity, arbiter, clock run, interrupt receiver
// Assumes: single-data-phase transfers started by the user side
// Notes: one transfer in flight at a time
module phs_host
    import phs_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // bus
    phs_if.host bus,
    // user side
    input wire logic start,
    input wire logic write,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [3:0] cmd_n,
    input wire logic [3:0] be_n,
    input wire logic grant_enable,
    input wire logic stop_clock,
    input wire logic serial_irq_in,
    output logic busy,
    output logic [31:0] rdata,
    output logic rdone,
    output logic read_parity_error,
    output logic perr_seen,
    output logic serr_seen,
    output logic [3:0] int_level,
    output logic clock_running
);
    typedef enum logic [1:0] {PHS_IDLE, PHS_ADDR, PHS_DATA, PHS_CHK} phs_hstate_t;
    phs_hstate_t state;
    logic [31:0] out_ad;
    logic [3:0] out_cbe;
    logic drive_ad, is_wr, par_q, par_oe, trdy_q;
    // ----------------------------------------
    // initiator sequence
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= PHS_IDLE;
            out_ad <= 32'h00000000;
            out_cbe <= 4'hF;
            drive_ad <= 1'b0;
            is_wr <= 1'b0;
            rdata <= 32'h00000000;
            rdone <= 1'b0;
            trdy_q <= 1'b0;
        end else begin
            rdone <= 1'b0;
            trdy_q <= 1'b0;
            unique case (state)
                PHS_IDLE: if (start) begin
                    state <= PHS_ADDR;
                    out_ad <= addr;
                    out_cbe <= cmd_n;
                    drive_ad <= 1'b1;
                    is_wr <= write;
                end
                PHS_ADDR: begin
                    state <= PHS_DATA;
                    out_ad <= wdata;
                    out_cbe <= be_n;
                    drive_ad <= is_wr;
                end
                PHS_DATA: if (!bus.trdy_n) begin
                    state <= PHS_CHK;
                    drive_ad <= 1'b0;
                    trdy_q <= 1'b1;
                    rdata <= bus.ad;
                    rdone <= !is_wr;
                end
                PHS_CHK: state <= PHS_IDLE;
            endcase
        end
    end
    assign busy = state != PHS_IDLE;
    assign bus.ad_host = out_ad;
    assign bus.ad_host_oe = drive_ad;
    assign bus.cbe_n = out_cbe;
    assign bus.frame_n = state != PHS_ADDR;
    assign bus.irdy_n = state != PHS_DATA;
    // ----------------------------------------
    // parity drive and read check
    // ----------------------------------------
    logic [3:0] rd_cbe;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            par_q <= 1'b0;
            par_oe <= 1'b0;
            rd_cbe <= 4'h0;
            read_parity_error <= 1'b0;
            perr_seen <= 1'b0;
            serr_seen <= 1'b0;
        end else begin
            par_q <= phs_parity(out_ad, out_cbe); // RL3 RL5
            par_oe <= drive_ad; // RL3
            rd_cbe <= out_cbe;
            read_parity_error <= trdy_q && !is_wr && phs_parity(rdata, rd_cbe) != bus.par; // RL4
            perr_seen <= !bus.perr_n;
            serr_seen <= !bus.serr_n;
        end
    end
    assign bus.par_host = par_q;
    assign bus.par_host_oe = par_oe;
    // ----------------------------------------
    // arbiter, clock run, interrupts
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus.gnt_n <= 1'b1;
            int_level <= 4'h0;
        end else begin
            bus.gnt_n <= !(grant_enable && !bus.req_n); // RL14
            int_level <= ~bus.int_pin;
        end
    end
    assign bus.clkrun_host_oe = !stop_clock; // RL13
    assign clock_running = !bus.clkrun_n; // RL13
    assign bus.int_host = 1'b0;
    assign bus.int_host_oe = serial_irq_in; // RL12
endmodule

/* dv/phs_sva.sv */
`timescale 1ns/100ps
// Purpose: assertions on the wires between device end and host end
// Assumes: one clock, asynchronous active-low reset
// Notes: watches resolved interface wires only
module phs_sva (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // bus wires
    input wire logic [31:0] ad,
    input wire logic [3:0] cbe_n,
    input wire logic frame_n,
    input wire logic irdy_n,
    input wire logic trdy_n,
    input wire logic devsel_n,
    input wire logic par,
    input wire logic perr_n,
    input wire logic serr_n,
    input wire logic req_n,
    input wire logic gnt_n
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // ----------------------------------------
    // parity and error lines
    // ----------------------------------------
    property p_addr_par;
        $fell(frame_n) |=> par == ^{$past(ad), $past(cbe_n)};
    endproperty
    a_addr_par: assert property (p_addr_par)
        else $error("address parity wrong");
    property p_data_par;
        (!irdy_n && !trdy_n) |=> par == ^{$past(ad), $past(cbe_n)};
    endproperty
    a_data_par: assert property (p_data_par)
        else $error("data parity wrong");
    property p_no_perr;
        (!irdy_n && !trdy_n) ##1 (par == ^{$past(ad), $past(cbe_n)}) |=> perr_n;
    endproperty
    a_no_perr: assert property (p_no_perr)
        else $error("parity error on good data");
    property p_no_serr;
        $fell(frame_n) ##1 (par == ^{$past(ad), $past(cbe_n)}) |=> serr_n;
    endproperty
    a_no_serr: assert property (p_no_serr)
        else $error("system error on good address");
    // ----------------------------------------
    // select, arbitration, reset
    // ----------------------------------------
    property p_trdy_sel;
        !trdy_n |-> !devsel_n;
    endproperty
    a_trdy_sel: assert property (p_trdy_sel)
        else $error("ready without select");
    property p_sel_decode;
        $fell(devsel_n) |-> !$past(frame_n);
    endproperty
    a_sel_decode: assert property (p_sel_decode)
        else $error("select without address phase");
    property p_grant;
        $fell(gnt_n) |-> !$past(req_n);
    endproperty
    a_grant: assert property (p_grant)
        else $error("grant without request");
    property p_reset;
        $rose(reset_n) |-> req_n && gnt_n && perr_n && serr_n && frame_n && trdy_n;
    endproperty
    a_reset: assert property (p_reset)
        else $error("lines not idle out of reset");
    c_xfer: cover property (!irdy_n && !trdy_n);
    c_grant: cover property ($fell(gnt_n));
    c_reset: cover property ($rose(reset_n));
endmodule

/* dv/pci_host_side_signaling_tb.sv */
`timescale 1ns/100ps
// Purpose: self-checking bench for both bus ends
// Assumes: sys_clk 100 ns, inputs driven 1 ns after the rising edge
// Notes: bus_b joins a spare device end to bench-driven bad parity
module pci_host_side_signaling_tb;
    import phs_pkg::*;
    logic sys_clk = 1'b0, reset_n = 1'b0, start = 1'b0, write = 1'b0, need_bus = 1'b0, clk_request = 1'b0;
    logic ring_enable = 1'b0, socket_status_ring_input = 1'b0, grant_enable = 1'b0, stop_clock = 1'b0;
    logic serial_irq_in = 1'b0, write_valid, bus_granted, dev_clk_run, host_clk_run, card_irq_seen, r1, target_seen;
    logic parity_error, address_error, busy, rdone, read_parity_error, perr_seen, serr_seen, parity_error2, address_error2;
    logic [31:0] base_addr = 32'h0000_4000, read_data = 32'h0, addr = 32'h0, wdata = 32'h0, write_data, rdata;
    logic [3:0] cmd_n = 4'hF, be_n = 4'h0, int_level;
    logic [15:0] irq_vector = 16'h0, sh;
    phs_mode_t int_mode = PHS_MODE_PCI;
    int errors = 0, num_checks = 0;
    always #50 sys_clk = ~sys_clk;
    phs_if bus_a();
    phs_if bus_b();
    phs_dev i_phs_dev (.sys_clk(sys_clk), .reset_n(reset_n), .bus(bus_a.dev), .base_addr(base_addr),
        .read_data(read_data), .need_bus(need_bus), .clk_request(clk_request), .int_mode(int_mode),
        .ring_enable(ring_enable), .socket_status_ring_input(socket_status_ring_input), .irq_vector(irq_vector),
        .write_data(write_data), .write_valid(write_valid), .bus_granted(bus_granted), .clock_running(dev_clk_run),
        .card_irq_seen(card_irq_seen), .target_seen(target_seen), .parity_error(parity_error),
        .address_error(address_error));
    phs_dev i_phs_dev_b (.sys_clk(sys_clk), .reset_n(reset_n), .bus(bus_b.dev), .base_addr(base_addr),
        .read_data(read_data), .need_bus(need_bus), .clk_request(clk_request), .int_mode(int_mode),
        .ring_enable(ring_enable), .socket_status_ring_input(socket_status_ring_input), .irq_vector(irq_vector),
        .write_data(), .write_valid(), .bus_granted(), .clock_running(), .card_irq_seen(), .target_seen(),
        .parity_error(parity_error2), .address_error(address_error2));
    phs_host i_phs_host (.sys_clk(sys_clk), .reset_n(reset_n), .bus(bus_a.host), .start(start), .write(write),
        .addr(addr), .wdata(wdata), .cmd_n(cmd_n), .be_n(be_n), .grant_enable(grant_enable), .stop_clock(stop_clock),
        .serial_irq_in(serial_irq_in), .busy(busy), .rdata(rdata), .rdone(rdone), .read_parity_error(read_parity_error),
        .perr_seen(perr_seen), .serr_seen(serr_seen), .int_level(int_level), .clock_running(host_clk_run));
    phs_sva i_phs_sva (.sys_clk(sys_clk), .reset_n(reset_n), .ad(bus_a.ad), .cbe_n(bus_a.cbe_n),
        .frame_n(bus_a.frame_n), .irdy_n(bus_a.irdy_n), .trdy_n(bus_a.trdy_n), .devsel_n(bus_a.devsel_n),
        .par(bus_a.par), .perr_n(bus_a.perr_n), .serr_n(bus_a.serr_n), .req_n(bus_a.req_n), .gnt_n(bus_a.gnt_n));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic check(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            errors++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic xfer(input logic wr, input logic [31:0] d);
        int n;
        logic seen, bad;
        n = 0;
        while (busy !== 1'b0 && n < 20) begin
            tick(1);
            n++;
        end
        write = wr;
        addr = base_addr;
        wdata = d;
        read_data = d;
        cmd_n = wr ? 4'h7 : 4'h3;
        start = 1'b1;
        tick(1);
        start = 1'b0;
        n = 0;
        seen = 1'b0;
        bad = 1'b0;
        while ((wr ? write_valid : rdone) !== 1'b1 && n < 8) begin
            seen = seen | target_seen;
            bad = bad | parity_error | address_error;
            tick(1);
            n++;
        end
        check((wr ? write_data : rdata) === d, "data mismatch");
        check(seen === 1'b1, "device select not observed");
        repeat (3) begin
            bad = bad | perr_seen | serr_seen | read_parity_error | parity_error | address_error;
            tick(1);
        end
        check(bad === 1'b0, "false parity error");
    endtask
    task automatic t_bad_par(input logic bad_a, input logic bad_d);
        bus_b.frame_n = 1'b0;
        bus_b.ad_host = base_addr;
        bus_b.ad_host_oe = 1'b1;
        bus_b.cbe_n = 4'h7;
        tick(1);
        bus_b.frame_n = 1'b1;
        bus_b.irdy_n = 1'b0;
        bus_b.par_host = (^{base_addr, 4'h7}) ^ bad_a;
        bus_b.par_host_oe = 1'b1;
        bus_b.ad_host = 32'h0000_0001;
        bus_b.cbe_n = 4'h0;
        tick(1);
        bus_b.irdy_n = 1'b1;
        bus_b.ad_host_oe = 1'b0;
        bus_b.par_host = 1'b1 ^ bad_d;
        check(address_error2 === bad_a && bus_b.serr_n === !bad_a, "address parity report");
        tick(1);
        bus_b.par_host_oe = 1'b0;
        check(bad_a || (parity_error2 === bad_d && bus_b.perr_n === !bad_d), "data parity report");
        check(bus_b.serr_n === 1'b1, "system error not a pulse");
        tick(3);
    endtask
    task automatic t_arb_clk;
        need_bus = 1'b1;
        grant_enable = 1'b1;
        tick(3);
        check(bus_a.req_n === 1'b0 && bus_a.gnt_n === 1'b0 && bus_granted === 1'b1, "grant missing");
        grant_enable = 1'b0;
        need_bus = 1'b0;
        tick(3);
        check(bus_a.req_n === 1'b1 && bus_granted === 1'b0, "grant not withdrawn");
        stop_clock = 1'b1;
        tick(2);
        check(bus_a.clkrun_n === 1'b1 && dev_clk_run === 1'b0, "clock run not released");
        clk_request = 1'b1;
        tick(2);
        check(bus_a.clkrun_n === 1'b0 && dev_clk_run === 1'b1, "clock run not pulled");
        clk_request = 1'b0;
        stop_clock = 1'b0;
        tick(2);
        check(bus_a.clkrun_n === 1'b0 && host_clk_run === 1'b1, "host clock run");
    endtask
    task automatic t_pins;
        int lows;
        irq_vector = 16'hC6AA;
        tick(3);
        check(bus_a.int_pin === 4'h5 && int_level === 4'hA, "pci interrupt pins");
        ring_enable = 1'b1;
        socket_status_ring_input = 1'b1;
        tick(3);
        r1 = bus_a.int_pin[1];
        socket_status_ring_input = 1'b0;
        tick(3);
        check((bus_a.int_pin[1] ^ r1) === 1'b1, "ring not forwarded");
        ring_enable = 1'b0;
        int_mode = PHS_MODE_EXT;
        for (int n = 0; n < 60; n++) begin
            sh = {bus_a.int_pin[3], sh[15:1]};
            if (bus_a.int_pin[2] === 1'b1 && n >= 16) break;
            tick(1);
        end
        check(sh === irq_vector, "shifted vector");
        check(bus_a.int_pin[1:0] === irq_vector[10:9], "ext request lines");
        int_mode = PHS_MODE_SERIAL;
        serial_irq_in = 1'b1;
        tick(8);
        check(card_irq_seen === 1'b1, "serial input not seen");
        lows = 0;
        repeat (4) begin
            lows += (bus_a.int_pin[2] === 1'b0);
            tick(1);
        end
        check(lows == 3, "serial output slots");
        serial_irq_in = 1'b0;
    endtask
    initial begin
        bus_b.ad_host = 32'h0;
        bus_b.ad_host_oe = 1'b0;
        bus_b.cbe_n = 4'hF;
        bus_b.frame_n = 1'b1;
        bus_b.irdy_n = 1'b1;
        bus_b.par_host = 1'b0;
        bus_b.par_host_oe = 1'b0;
        bus_b.gnt_n = 1'b1;
        bus_b.clkrun_host_oe = 1'b1;
        bus_b.int_host = 1'b1;
        bus_b.int_host_oe = 1'b0;
        tick(1);
        check(bus_a.ad === 32'hFFFF_FFFF && bus_a.req_n === 1'b1 && write_valid === 1'b0, "reset state");
        tick(1);
        reset_n = 1'b1;
        xfer(1'b1, 32'hA5A5_0F0F);
        xfer(1'b1, 32'hFFFF_FFFF);
        xfer(1'b0, 32'h1234_5678);
        xfer(1'b0, 32'h0000_0000);
        t_bad_par(1'b1, 1'b0);
        t_bad_par(1'b0, 1'b1);
        t_arb_clk;
        t_pins;
        wrap_up;
    end
    // watchdog: about forty times the expected run
    initial begin
        #400000;
        errors++;
        wrap_up;
    end
endmodule
